// ===== design/pvmr_map.vh
`ifndef PVMR_MAP_VH
`define PVMR_MAP_VH
// Register byte offsets.
`define PVMR_OFF_ICR    8'h00
`define PVMR_OFF_AMSR   8'h04
`define PVMR_OFF_BTDR   8'h08
`define PVMR_OFF_BTCR   8'h0C
`define PVMR_OFF_BTLR0  8'h10
`define PVMR_OFF_BTLR1  8'h14
`define PVMR_OFF_ARB    8'h18
`define PVMR_OFF_DMAICR 8'h1C
`define PVMR_OFF_EGIVBR 8'h20
`define PVMR_OFF_BESR   8'h24
`define PVMR_OFF_RCR    8'hD0
// Reset values.
`define PVMR_RST_BYTE   8'h00
// Field positions.
`define PVMR_ICR_ATOM_HI 7
`define PVMR_ICR_ATOM_LO 5
`define PVMR_ATOM_ON     3'h1
`define PVMR_BTDR_D32    0
`define PVMR_BTDR_D64    4
`define PVMR_BTDR_X2K    7
`define PVMR_BTCR_EN     7
`define PVMR_BTCR_DIR    6
`define PVMR_BESR_INV    0
`define PVMR_BESR_DONE   1
// Release modes.
`define PVMR_REL_ROR     2'h0
`define PVMR_REL_RWD     2'h1
`define PVMR_REL_ROC     2'h2
`define PVMR_REL_HOLD    2'h3
// Address sizes.
`define PVMR_AS_USER     2'h0
`define PVMR_AS_A32      2'h1
`define PVMR_AS_A16      2'h2
`define PVMR_AS_A24      2'h3
// Data widths.
`define PVMR_W_D08       2'h0
`define PVMR_W_D16       2'h1
`define PVMR_W_D32       2'h2
`define PVMR_W_D64       2'h3
// Timing.
`define PVMR_CLK_NS        50
`define PVMR_FAIR_UNIT_NS  2000
`define PVMR_FAIR_UNIT_CYC ((`PVMR_FAIR_UNIT_NS + `PVMR_CLK_NS - 1) / `PVMR_CLK_NS)
`define PVMR_GAP_UNIT_NS   1000
`define PVMR_GAP_UNIT_CYC  ((`PVMR_GAP_UNIT_NS + `PVMR_CLK_NS - 1) / `PVMR_CLK_NS)
`endif

// ===== design/pvmr_master_requester.v
`timescale 1ns/1ns
`include "pvmr_map.vh"
module pvmr_master_requester (
  input  wire        clk_sys,        // System clock, 20 MHz.
  input  wire        rst_n,          // Asynchronous reset, active low.
  input  wire [7:0]  avs_address,    // Avalon byte address.
  input  wire        avs_read,       // Avalon read request.
  input  wire        avs_write,      // Avalon write request.
  input  wire [31:0] avs_writedata,  // Avalon write data.
  input  wire [3:0]  avs_byteenable, // Avalon byte enables.
  output wire        avs_waitrequest,// Avalon wait request.
  output reg  [31:0] avs_readdata,   // Avalon read data.
  input  wire        pio_req,        // Window access request, held until done.
  input  wire        pio_write,      // Window access is a write.
  input  wire [3:0]  pio_be,         // Byte enables of the window access.
  input  wire [17:0] pio_offset,     // Byte offset inside the page.
  input  wire [31:0] pio_wdata,      // Window write data.
  input  wire        sg_valid,       // Page entry valid bit.
  input  wire [1:0]  sg_asize,       // Page entry address size field.
  input  wire [1:0]  sg_fcode,       // Page entry function code field.
  input  wire        sg_atomic,      // Page entry atomic pair bit.
  input  wire [13:0] sg_page,        // Page entry VME page number.
  output reg         pio_done,       // One-cycle pulse, access finished.
  output reg         pio_err,        // With pio_done, entry was invalid.
  output reg         vme_cyc_req,    // VME cycle request, held until ack.
  input  wire        vme_cyc_ack,    // VME cycle finished.
  output reg  [31:0] vme_addr,       // VME address of the cycle.
  output reg  [5:0]  vme_am,         // VME address modifier.
  output reg  [1:0]  vme_width,      // Cycle width code.
  output reg         vme_wr,         // Cycle is a write.
  output reg         vme_blk,        // Cycle is part of a block.
  output reg  [31:0] vme_wdata,      // Single cycle write data.
  output reg  [3:0]  vme_br,         // Bus request lines, one hot.
  input  wire [3:0]  vme_br_in,      // Requests seen from other masters.
  input  wire        vme_bg_in,      // Bus grant to this device.
  input  wire        vme_bclr_in,    // Bus clear from system controller.
  output reg         vme_bbsy,       // Bus busy, this device owns the bus.
  output wire        dma_irq,        // DMA completion interrupt level.
  output wire [7:0]  dma_vector      // Vector presented with dma_irq.
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ARB  = 3'h1;
  localparam ST_PIO  = 3'h2;
  localparam ST_BEAT = 3'h3;
  localparam ST_GAP  = 3'h4;

  reg [7:0]  icr_q, amsr_q, btdr_q, btcr_q, btlr0_q, btlr1_q;
  reg [7:0]  arb_q, dmaicr_q, egivbr_q, rcr_q;
  reg [1:0]  besr_q;
  reg        ack_q;
  reg [2:0]  st_q;
  reg        own_q, hold_q, dma_q;
  reg [16:0] left_q;
  reg [8:0]  beats_q;
  reg [9:0]  wait_q;
  reg        set_done;
  reg        set_inv;

  wire wr_acc = avs_write & ack_q;
  wire rd_acc = avs_read & ~ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: every access waits exactly one cycle. Reads are captured on
  // the first edge, so the data stand while waitrequest is low; writes land
  // on the accepting edge.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // Accept toggle.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Register writes; only byte lane 0 holds data.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      icr_q    <= `PVMR_RST_BYTE;
      amsr_q   <= `PVMR_RST_BYTE;
      btdr_q   <= `PVMR_RST_BYTE;
      btcr_q   <= `PVMR_RST_BYTE;
      btlr0_q  <= `PVMR_RST_BYTE;
      btlr1_q  <= `PVMR_RST_BYTE;
      arb_q    <= `PVMR_RST_BYTE;
      dmaicr_q <= `PVMR_RST_BYTE;
      egivbr_q <= `PVMR_RST_BYTE;
      rcr_q    <= `PVMR_RST_BYTE;
    end else if (wr_acc && avs_byteenable[0]) begin
      if (avs_address == `PVMR_OFF_ICR) begin
        icr_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_AMSR) begin
        amsr_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_BTDR) begin
        btdr_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_BTCR) begin
        btcr_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_BTLR0) begin
        btlr0_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_BTLR1) begin
        btlr1_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_ARB) begin
        arb_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_DMAICR) begin
        dmaicr_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_EGIVBR) begin
        egivbr_q <= avs_writedata[7:0];
      end else if (avs_address == `PVMR_OFF_RCR) begin
        rcr_q <= avs_writedata[7:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_acc) begin
      if (avs_address == `PVMR_OFF_ICR) begin
        avs_readdata <= {24'h000000, icr_q};
      end else if (avs_address == `PVMR_OFF_AMSR) begin
        avs_readdata <= {24'h000000, amsr_q};
      end else if (avs_address == `PVMR_OFF_BTDR) begin
        avs_readdata <= {24'h000000, btdr_q};
      end else if (avs_address == `PVMR_OFF_BTCR) begin
        avs_readdata <= {24'h000000, btcr_q};
      end else if (avs_address == `PVMR_OFF_BTLR0) begin
        avs_readdata <= {24'h000000, btlr0_q};
      end else if (avs_address == `PVMR_OFF_BTLR1) begin
        avs_readdata <= {24'h000000, btlr1_q};
      end else if (avs_address == `PVMR_OFF_ARB) begin
        avs_readdata <= {24'h000000, arb_q};
      end else if (avs_address == `PVMR_OFF_DMAICR) begin
        avs_readdata <= {24'h000000, dmaicr_q};
      end else if (avs_address == `PVMR_OFF_EGIVBR) begin
        avs_readdata <= {24'h000000, egivbr_q};
      end else if (avs_address == `PVMR_OFF_BESR) begin
        avs_readdata <= {30'h00000000, besr_q};
      end else if (avs_address == `PVMR_OFF_RCR) begin
        avs_readdata <= {24'h000000, rcr_q};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  // Sticky status, write one to clear; a hardware set in the same cycle wins.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      besr_q <= 2'h0;
    end else begin
      if (set_inv) begin
        besr_q[`PVMR_BESR_INV] <= 1'b1;
      end else if (wr_acc && avs_address == `PVMR_OFF_BESR &&
                   avs_writedata[`PVMR_BESR_INV]) begin
        besr_q[`PVMR_BESR_INV] <= 1'b0;
      end
      if (set_done) begin
        besr_q[`PVMR_BESR_DONE] <= 1'b1;
      end else if (wr_acc && avs_address == `PVMR_OFF_BESR &&
                   avs_writedata[`PVMR_BESR_DONE]) begin
        besr_q[`PVMR_BESR_DONE] <= 1'b0;
      end
    end
  end

  // Completion interrupt gated by its enable, vector from the base register.
  assign dma_irq    = besr_q[`PVMR_BESR_DONE] & dmaicr_q[0];
  assign dma_vector = egivbr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Modifier formation. User-defined size bypasses block conversion.
  function [5:0] pvmr_am;
    input [1:0] asz;
    input [1:0] fc;
    input       blk;
    input       d64;
    input [5:0] user;
    begin
      pvmr_am = user;
      if (asz == `PVMR_AS_A32) begin
        if (blk) begin
          pvmr_am = d64 ? (fc[1] ? 6'h0C : 6'h08) : (fc[1] ? 6'h0F : 6'h0B);
        end else begin
          pvmr_am = {4'h0, fc[1], 1'b0} + 6'h09 + {5'h00, fc[0]} + {4'h0, fc[1], 1'b0};
        end
      end else if (asz == `PVMR_AS_A24) begin
        if (blk) begin
          pvmr_am = d64 ? (fc[1] ? 6'h3C : 6'h38) : (fc[1] ? 6'h3F : 6'h3B);
        end else begin
          pvmr_am = {4'h0, fc[1], 1'b0} + 6'h39 + {5'h00, fc[0]} + {4'h0, fc[1], 1'b0};
        end
      end else if (asz == `PVMR_AS_A16) begin
        pvmr_am = fc[1] ? 6'h2D : 6'h29;
      end
    end
  endfunction

  // Width of a single access from its byte enables.
  function [1:0] pvmr_width;
    input [3:0] be;
    begin
      if (be == 4'hF) begin
        pvmr_width = `PVMR_W_D32;
      end else if (be == 4'h3 || be == 4'hC) begin
        pvmr_width = `PVMR_W_D16;
      end else begin
        pvmr_width = `PVMR_W_D08;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // DMA geometry.
  wire       d64      = btdr_q[`PVMR_BTDR_D64];
  wire [1:0] dma_w    = d64 ? `PVMR_W_D64 : (btdr_q[`PVMR_BTDR_D32] ? `PVMR_W_D32 : `PVMR_W_D16);
  wire [3:0] step     = d64 ? 4'h8 : (btdr_q[`PVMR_BTDR_D32] ? 4'h4 : 4'h2);
  wire [6:0] blen     = (rcr_q[5:0] == 6'h00) ? 7'h40 : {1'b0, rcr_q[5:0]};
  wire [8:0] blimit   = d64 ? {blen, 2'h0} : {2'h0, blen};
  wire [31:0] nxt_adr = vme_addr + {28'h0000000, step};
  wire       bound    = d64 ? (nxt_adr[10:0] == 11'h000) : (nxt_adr[7:0] == 8'h00);
  wire [16:0] nxt_left = left_q - {13'h0000, step};
  wire       atom_ok  = icr_q[`PVMR_ICR_ATOM_HI:`PVMR_ICR_ATOM_LO] == `PVMR_ATOM_ON;
  wire [1:0] rel_mode = rcr_q[7:6];

  ////////////////////////////////////////////////////////////////////////////
  // Requester: fairness standoff counted in 2 us units.
  reg [9:0] fair_q;
  wire      others   = |vme_br_in;
  wire      fair_on  = arb_q[7:4] != 4'h0;
  wire      fair_inf = arb_q[7:4] == 4'hF;
  wire      fair_exp = fair_q >= arb_q[7:4] * `PVMR_FAIR_UNIT_CYC;
  wire      may_req  = ~fair_on | ~others | (~fair_inf & fair_exp);

  // Standoff timer runs only while arbitrating with others on the bus.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fair_q <= 10'h000;
    end else if (st_q == ST_ARB && others && !own_q && !fair_exp) begin
      fair_q <= fair_q + 10'h001;
    end else if (st_q != ST_ARB) begin
      fair_q <= 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= ST_IDLE;
      own_q       <= 1'b0;
      hold_q      <= 1'b0;
      dma_q       <= 1'b0;
      left_q      <= 17'h00000;
      beats_q     <= 9'h000;
      wait_q      <= 10'h000;
      pio_done    <= 1'b0;
      pio_err     <= 1'b0;
      vme_cyc_req <= 1'b0;
      vme_addr    <= 32'h00000000;
      vme_am      <= 6'h00;
      vme_width   <= 2'h0;
      vme_wr      <= 1'b0;
      vme_blk     <= 1'b0;
      vme_wdata   <= 32'h00000000;
      vme_br      <= 4'h0;
      vme_bbsy    <= 1'b0;
      set_done    <= 1'b0;
      set_inv     <= 1'b0;
    end else begin
      pio_done <= 1'b0;
      pio_err  <= 1'b0;
      set_done <= 1'b0;
      set_inv  <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // Release decision while idle and owning the bus.
          if (own_q && !hold_q) begin
            if ((rel_mode == `PVMR_REL_RWD) ||
                (rel_mode == `PVMR_REL_ROR && others) ||
                (rel_mode == `PVMR_REL_ROC && vme_bclr_in)) begin
              own_q    <= 1'b0;
              vme_bbsy <= 1'b0;
            end
          end
          if (pio_req && !pio_done) begin
            if (!sg_valid) begin
              pio_done <= 1'b1;
              pio_err  <= 1'b1;
              set_inv  <= 1'b1;
            end else begin
              vme_addr  <= {sg_page, pio_offset};
              vme_am    <= pvmr_am(sg_asize, sg_fcode, 1'b0, 1'b0, amsr_q[5:0]);
              vme_width <= pvmr_width(pio_be);
              vme_wr    <= pio_write;
              vme_wdata <= pio_wdata;
              vme_blk   <= 1'b0;
              // A write while DMA is enabled starts the block engine.
              dma_q     <= pio_write & btcr_q[`PVMR_BTCR_EN];
              left_q    <= {(btlr1_q == 8'h00 && btlr0_q == 8'h00), btlr1_q, btlr0_q};
              if (pio_write && btcr_q[`PVMR_BTCR_EN]) begin
                vme_am    <= pvmr_am(sg_asize, sg_fcode, 1'b1, d64, amsr_q[5:0]);
                vme_width <= dma_w;
                vme_wr    <= btcr_q[`PVMR_BTCR_DIR];
                vme_blk   <= 1'b1;
                pio_done  <= 1'b1;
              end
              st_q <= ST_ARB;
            end
          end
        end
        ST_ARB: begin
          // Capture-and-hold ignores other requests and keeps its claim.
          if (own_q) begin
            vme_br <= 4'h0;
            st_q   <= dma_q ? ST_BEAT : ST_PIO;
            beats_q <= 9'h000;
          end else if (vme_bg_in && vme_br != 4'h0) begin
            own_q    <= 1'b1;
            vme_bbsy <= 1'b1;
            vme_br   <= 4'h0;
          end else if (may_req) begin
            vme_br <= 4'h1 << arb_q[1:0];
          end
        end
        ST_PIO: begin
          vme_cyc_req <= ~(vme_cyc_req & vme_cyc_ack);
          if (vme_cyc_req && vme_cyc_ack) begin
            pio_done <= 1'b1;
            // First of a pair arms the hold; the following access ends it.
            hold_q   <= ~hold_q & sg_atomic & atom_ok;
            st_q     <= ST_IDLE;
          end
        end
        ST_BEAT: begin
          vme_cyc_req <= ~(vme_cyc_req & vme_cyc_ack);
          if (vme_cyc_req && vme_cyc_ack) begin
            vme_addr <= nxt_adr;
            left_q   <= nxt_left;
            beats_q  <= beats_q + 9'h001;
            if (nxt_left == 17'h00000) begin
              dma_q    <= 1'b0;
              set_done <= 1'b1;
              st_q     <= ST_IDLE;
            end else if (bound || (beats_q + 9'h001) == blimit) begin
              // Give the bus up between bursts, except in capture-and-hold, so other masters can get in.
              if (rel_mode != `PVMR_REL_HOLD) begin
                own_q    <= 1'b0;
                vme_bbsy <= 1'b0;
              end
              wait_q <= {btcr_q[3:0], 6'h00} >> 1;
              st_q   <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (wait_q == 10'h000) begin
            st_q <= ST_ARB;
          end else begin
            wait_q <= wait_q - 10'h001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      // Capture-and-hold keeps any acquired ownership.
      if (rel_mode == `PVMR_REL_HOLD && own_q) begin
        own_q    <= 1'b1;
        vme_bbsy <= 1'b1;
      end
    end
  end

endmodule // pvmr_master_requester

// ===== testbench/pvmr_sva.sv
`timescale 1ns/1ns
module pvmr_sva (
  input wire logic       clk_sys,         // Clock.
  input wire logic       rst_n,           // Reset.
  input wire logic       avs_read,        // Read.
  input wire logic       avs_waitrequest, // Wait.
  input wire logic       pio_req,         // Access.
  input wire logic [3:0] pio_be,          // Enables.
  input wire logic       sg_valid,        // Valid.
  input wire logic [1:0] sg_asize,        // Size.
  input wire logic [1:0] sg_fcode,        // Code.
  input wire logic       pio_done,        // Done.
  input wire logic       pio_err,         // Error.
  input wire logic       vme_cyc_req,     // Cycle.
  input wire logic       vme_cyc_ack,     // Ack.
  input wire logic [5:0] vme_am,          // Modifier.
  input wire logic [1:0] vme_width,       // Width.
  input wire logic       vme_blk,         // Block.
  input wire logic [3:0] vme_br,          // Request.
  input wire logic       vme_bbsy         // Owner.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Fixed modifier table; size 00 is left out since its code sits in a register.
  function automatic logic [5:0] am_of(logic [1:0] a, logic [1:0] f);
    if (a == 2'h2) return f[1] ? 6'h2D : 6'h29;
    return (a == 2'h1 ? 6'h08 : 6'h38) + (f[1] ? 6'h05 : 6'h01) + {5'h00, f[0]};
  endfunction
  function automatic logic [1:0] wd_of(logic [3:0] be);
    return ($countones(be) == 4) ? 2'h2 : ($countones(be) == 2) ? 2'h1 : 2'h0;
  endfunction
  sequence s_bad_entry;
    $rose(pio_req) && !sg_valid;
  endsequence
  sequence s_taken;
    vme_cyc_req && vme_cyc_ack && pio_req;
  endsequence
  sequence s_new_cyc;
    $rose(vme_cyc_req) && pio_req && !vme_blk;
  endsequence
  a_bad_no_cyc: assert property (s_bad_entry |-> !vme_cyc_req [*3])
    else $error("Cycle started for an invalid entry.");
  a_bad_flag: assert property (s_bad_entry |-> ##[1:3] (pio_done && pio_err))
    else $error("Invalid entry not flagged.");
  a_am_single: assert property (s_new_cyc ##0 sg_asize != 2'h0 |->
    vme_am == am_of(sg_asize, sg_fcode)) else $error("Wrong single modifier.");
  a_width_be: assert property (s_new_cyc |-> vme_width == wd_of(pio_be))
    else $error("Width does not follow byte enables.");
  a_br_level: assert property ($onehot0(vme_br))
    else $error("More than one request line.");
  a_req_holds: assert property (vme_cyc_req && !vme_cyc_ack |=>
    vme_cyc_req && $stable(vme_am)) else $error("Cycle request dropped early.");
  a_req_owned: assert property (vme_cyc_req |-> vme_bbsy)
    else $error("Cycle without bus ownership.");
  a_done_after: assert property (s_taken |-> ##[1:3] pio_done)
    else $error("Access not finished after ack.");
  a_done_pulse: assert property (pio_done |=> !pio_done)
    else $error("Done longer than one cycle.");
  a_avs_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Read answer latency wrong.");
endmodule // pvmr_sva

bind pvmr_master_requester pvmr_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_read(avs_read), .avs_waitrequest(avs_waitrequest), .pio_req(pio_req),
  .pio_be(pio_be), .sg_valid(sg_valid), .sg_asize(sg_asize), .sg_fcode(sg_fcode),
  .pio_done(pio_done), .pio_err(pio_err), .vme_cyc_req(vme_cyc_req),
  .vme_cyc_ack(vme_cyc_ack), .vme_am(vme_am), .vme_width(vme_width),
  .vme_blk(vme_blk), .vme_br(vme_br), .vme_bbsy(vme_bbsy));

// ===== testbench/pvmr_vme_model.sv
`timescale 1ns/1ns
module pvmr_vme_model (
  input  wire logic       clk_sys,     // Clock.
  input  wire logic       rst_n,       // Reset.
  input  wire logic       slow,        // Stretch the slave answer.
  input  wire logic       vme_cyc_req, // Cycle request.
  input  wire logic [3:0] vme_br,      // Request lines.
  output logic            vme_cyc_ack, // Slave answer.
  output logic            vme_bg_in    // Grant.
);
  logic [2:0] wait_q;
  // Grant follows any request; ack comes once per request, at once or late.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 3'h0;
      vme_cyc_ack <= 1'b0;
      vme_bg_in <= 1'b0;
    end else begin
      vme_bg_in <= |vme_br;
      wait_q <= (vme_cyc_req && !vme_cyc_ack) ? wait_q + 3'h1 : 3'h0;
      vme_cyc_ack <= vme_cyc_req && !vme_cyc_ack && (wait_q >= (slow ? 3'h3 : 3'h0));
    end
  end
endmodule // pvmr_vme_model

// ===== testbench/pci_to_vme_master_requester_tb_top.sv
`timescale 1ns/1ns
`include "pvmr_map.vh"
module pci_to_vme_master_requester_tb_top;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, pio_req, pio_write;
  logic        sg_valid, pio_done, pio_err, vme_cyc_req, vme_cyc_ack, vme_blk, vme_bg_in;
  logic        vme_bclr_in, vme_bbsy, slow, sg_atomic, dma_irq;
  logic [7:0]  avs_address, dma_vec;
  logic [31:0] avs_writedata, avs_readdata, pio_wdata, q;
  logic [3:0]  pio_be, vme_br, vme_br_in;
  logic [17:0] pio_offset;
  logic [13:0] sg_page;
  logic [1:0]  sg_asize, sg_fcode, vme_width;
  logic [5:0]  vme_am, amsr;
  logic [5:0]  am_q[$];
  logic [3:0]  bes[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  int          bad_count, total_checks, cyc, n, g;
  pvmr_master_requester DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .pio_req(pio_req), .pio_write(pio_write), .pio_be(pio_be), .pio_offset(pio_offset),
    .pio_wdata(pio_wdata), .sg_valid(sg_valid), .sg_asize(sg_asize), .sg_fcode(sg_fcode),
    .sg_atomic(sg_atomic), .sg_page(sg_page), .pio_done(pio_done), .pio_err(pio_err),
    .vme_cyc_req(vme_cyc_req), .vme_cyc_ack(vme_cyc_ack), .vme_addr(), .vme_am(vme_am),
    .vme_width(vme_width), .vme_wr(), .vme_blk(vme_blk), .vme_wdata(), .vme_br(vme_br),
    .vme_br_in(vme_br_in), .vme_bg_in(vme_bg_in), .vme_bclr_in(vme_bclr_in),
    .vme_bbsy(vme_bbsy), .dma_irq(dma_irq), .dma_vector(dma_vec));
  pvmr_vme_model u_vme (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
    .vme_cyc_req(vme_cyc_req), .vme_br(vme_br), .vme_cyc_ack(vme_cyc_ack),
    .vme_bg_in(vme_bg_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Reference modifier; size 00 returns whatever software put in the select register.
  function automatic logic [5:0] am_ref(int a, int f);
    int b;
    b = (a == 1) ? 32'h08 : 32'h38;
    if (a == 0) return amsr;
    if (a == 2) return (f >= 2) ? 6'h2D : 6'h29;
    return 6'(b + ((f >= 2) ? 5 : 1) + f % 2);
  endfunction
  function automatic logic [1:0] wd_ref(logic [3:0] be);
    int c;
    c = $countones(be);
    return (c == 4) ? `PVMR_W_D32 : (c == 2) ? `PVMR_W_D16 : `PVMR_W_D08;
  endfunction
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge, takes the
  // read data at that edge and releases the request there.
  task av(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task pio(int a, int f, logic [3:0] be, logic v);
    logic seen;
    logic [31:0] r;
    r = $urandom;
    @(posedge clk_sys);
    {pio_req, sg_valid, pio_be, pio_wdata} <= {1'b1, v, be, r};
    {sg_asize, sg_fcode, pio_write, slow} <= {a[1:0], f[1:0], r[0], r[5]};
    {pio_offset, sg_page} <= r;
    if (v) am_q.push_back(am_ref(a, f));
    seen = 1'b0;
    do begin
      @(negedge clk_sys);
      if (vme_cyc_req === 1'b1 && am_q.size() > 0) begin
        chk("am", am_q.pop_front(), vme_am);
        chk("width", wd_ref(be), vme_width);
      end
      if (vme_cyc_req === 1'b1) seen = 1'b1;
    end while (pio_done !== 1'b1);
    chk("pio_err", !v, pio_err);
    chk("cycle_seen", v, seen);
    @(posedge clk_sys);
    pio_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, pio_req, pio_write} = '0;
    {pio_be, pio_offset, pio_wdata, sg_valid, sg_asize, sg_fcode, sg_page} = '0;
    {vme_br_in, vme_bclr_in, slow, sg_atomic} = '0;
    void'($urandom(20457));
    amsr = $urandom;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    av(1'b0, `PVMR_OFF_RCR, 0);
    chk("rcr_reset", `PVMR_RST_BYTE, q);
    av(1'b0, 8'h40, 0);
    chk("unmapped", 0, q);
    av(1'b1, `PVMR_OFF_ICR, 32'h20);
    av(1'b1, `PVMR_OFF_AMSR, {26'h0, amsr});
    av(1'b0, `PVMR_OFF_AMSR, 0);
    chk("amsr", {26'h0, amsr}, q);
    av(1'b1, `PVMR_OFF_ARB, 32'hF2);
    vme_br_in <= 4'h1;
    fork
      pio(1, 0, 4'hF, 1'b1);
      begin
        repeat (20) begin
          @(negedge clk_sys);
          chk("fair_hold", 0, vme_br);
        end
        @(posedge clk_sys);
        vme_br_in <= 4'h0;
        n = 0;
        do begin
          @(negedge clk_sys);
          n++;
        end while (vme_br === 4'h0 && n < 20);
        chk("req_level", 4'h4, vme_br);
      end
    join
    for (int a = 0; a < 4; a++) for (int f = 0; f < 4; f++) pio(a, f, bes[$urandom % 7], 1'b1);
    pio(1, 2, 4'hF, 1'b0);
    av(1'b0, `PVMR_OFF_BESR, 0);
    chk("besr_set", 1, q[0]);
    av(1'b1, `PVMR_OFF_BESR, 32'h1);
    av(1'b0, `PVMR_OFF_BESR, 0);
    chk("besr_clr", 0, q[0]);
    // Each mode but release-when-done: kept after the access, then offered the causes that free the others; capture-and-hold keeps the bus.
    for (int m = 0; m < 4; m++) begin
      av(1'b1, `PVMR_OFF_RCR, m << 6);
      pio(3, m, 4'h3, 1'b1);
      repeat (4) @(negedge clk_sys);
      chk("bbsy_kept", m != 1, vme_bbsy);
      @(posedge clk_sys);
      vme_br_in <= (m == 0 || m == 3) ? 4'h2 : 4'h0;
      vme_bclr_in <= (m >= 2);
      repeat (4) @(negedge clk_sys);
      chk("bbsy_freed", m == 3, vme_bbsy);
      @(posedge clk_sys);
      {vme_br_in, vme_bclr_in} <= 5'h00;
    end
    av(1'b1, `PVMR_OFF_RCR, 0);
    vme_br_in <= 4'h2;
    repeat (4) @(negedge clk_sys);
    chk("hold_left", 0, vme_bbsy);
    // An atomic pair keeps the bus in release-when-done until its second access ends.
    @(posedge clk_sys);
    vme_br_in <= 4'h0;
    av(1'b1, `PVMR_OFF_RCR, 32'h42);
    sg_atomic <= 1'b1;
    pio(3, 0, 4'hF, 1'b1);
    sg_atomic <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("pair_held", 1, vme_bbsy);
    pio(3, 0, 4'hF, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("pair_freed", 0, vme_bbsy);
    // Eight D16 bytes from an aligned start, bursts of two beats with a gap between.
    av(1'b1, `PVMR_OFF_BTLR0, 32'h8);
    av(1'b1, `PVMR_OFF_DMAICR, 32'h1);
    av(1'b1, `PVMR_OFF_EGIVBR, 32'h5A);
    av(1'b1, `PVMR_OFF_BTCR, 32'hC1);
    {sg_asize, sg_fcode, sg_page, pio_offset} <= {4'hC, 32'h0};
    {pio_req, pio_write, sg_valid} <= 3'h7;
    @(negedge clk_sys iff pio_done === 1'b1);
    @(posedge clk_sys);
    pio_req <= 1'b0;
    n = 0;
    g = 0;
    do begin
      @(negedge clk_sys);
      if (vme_cyc_req === 1'b1) chk("blk_am", 6'h3B, vme_am);
      if (vme_cyc_req === 1'b1 && vme_cyc_ack === 1'b1) n++;
      if (vme_bbsy === 1'b0) g++;
    end while (dma_irq !== 1'b1);
    chk("dma_beats", 4, n);
    chk("dma_gap", 1, g >= 32);
    chk("dma_vector", 32'h5A, dma_vec);
    av(1'b1, `PVMR_OFF_BTCR, 32'h0);
    stop_test();
  end
endmodule // pci_to_vme_master_requester_tb_top
